/* logic/rewriter_pipe_consts.vh */
`ifndef REWRITER_PIPE_CONSTS_VH
`define REWRITER_PIPE_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave.
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_FRAMES_OFS 8'h08
`define REG_LOOPS_OFS 8'h0c

// Control register fields and reset value.
`define CTRL_ENABLE_BIT 0
`define CTRL_LOOP_ONCE_BIT 1
`define CTRL_RESET 2'h1

// Status register field positions.
`define STAT_POINT_LSB 0
`define STAT_ACTION_LSB 4
`define STAT_FWD_LSB 8

// AXI response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Rewriter pipeline point positions.
`define PT_NONE 4'h0
`define PT_INNER_INTERMEDIATE 4'h1
`define PT_INNER_SOFTWARE_ENDPOINT 4'h2
`define PT_INNER_SERVICE_OAM 4'h3
`define PT_OUTER_SERVICE_OAM 4'h4
`define PT_OUTER_SOFTWARE_ENDPOINT 4'h5
`define PT_OUTER_INTERMEDIATE 4'h6
`define PT_SATELLITE_TEST 4'h7
`define PT_PORT_OAM 4'h8
`define PT_REPLY_FRAME 4'h9
`define PT_COUNT 10

// Pipeline action codes.
`define ACT_NONE 4'h0
`define ACT_INJECT 4'h1
`define ACT_INJECT_MASQUERADE 4'h2
`define ACT_INJECT_CENTRAL 4'h3
`define ACT_EXTRACT 4'h4
`define ACT_EXTRACT_UP_ENDPOINT 4'h5
`define ACT_EXTRACT_LATE 4'h6
`define ACT_LOOPBACK_TO_ANALYZER 4'h7
`define ACT_QUEUE_SYSTEM_LOOPBACK 4'h8

// Forward selector codes.
`define FWD_NONE 2'h0
`define FWD_COPY 2'h1
`define FWD_REDIRECT 2'h2
`define FWD_DISCARD 2'h3

// Classifier pipeline point field codes.
`define CLS_PT_INNER_SW 2'h0
`define CLS_PT_OUTER_SW 2'h1
`define CLS_PT_SAT 2'h2

// Analyzer point codes of a frame looped by the analyzer.
`define ANA_PT_PORT_OAM 2'h1
`define ANA_PT_OUTER_OAM 2'h2
`define ANA_PT_INNER_OAM 2'h3

// OAM processor point select codes.
`define OAM_PT_INNER 2'h0
`define OAM_PT_OUTER 2'h1
`define OAM_PT_PORT 2'h2

// Source MAC bit cleared after an exchange.
`define MAC_LOCAL_BIT 40

`endif

/* logic/stage_presence_mask.v */
`timescale 1ns/1ps
`include "rewriter_pipe_consts.vh"

module stage_presence_mask #(
	parameter NPOS = `PT_COUNT
) (
	input wire [3:0] point,
	input wire [3:0] action,
	output wire [NPOS-1:0] present
);
	wire injectLike;
	wire extractLike;

	assign injectLike = (action == `ACT_INJECT) || (action == `ACT_INJECT_MASQUERADE) ||
		(action == `ACT_INJECT_CENTRAL) || (action == `ACT_QUEUE_SYSTEM_LOOPBACK);
	assign extractLike = (action == `ACT_EXTRACT) || (action == `ACT_EXTRACT_UP_ENDPOINT) ||
		(action == `ACT_EXTRACT_LATE) || (action == `ACT_LOOPBACK_TO_ANALYZER);

	genvar k;
	generate
		for (k = 0; k < NPOS; k = k + 1) begin : gPos
			// A frame logically exists only between its injection and extraction points.
			assign present[k] = injectLike ? (k[3:0] >= point) : (extractLike ? (k[3:0] <= point) : 1'b1);
		end
	endgenerate
endmodule

/* logic/egress_rewriter_pipeline_control.v */
// Notes on behaviour
// - Nonzero forward selector reads action bit: 0 extract to CPU queue, 1 loopback.
// - MAC exchange only for copy, or redirect with loopback action.
// - Forced loop forces redirect, loopback, satellite point, MAC exchange, no CPU queue.
// - Without forced loop, use configured classifier point and forward selector.
// - Pipeline points are ordered none 0 through reply frame 9.
// - Every frame passes all stages; stages are only logically disabled.
// - Analyzer injection actions are reset to no point and no action on entry.
// - Extract set by classifier and intermediate point, up-endpoint by OAM; late only analyzer.
// - Queue-system loopback counts as an injection action here.
// - Loopback to analyzer counts as an extraction here.
// - Default frame state is no point and no action, no restriction.
// - Analyzer port, outer and inner OAM points map to rewriter equivalents.
// - Forwarding and counting decisions follow each frame's point and action.
// - Only classifier, intermediate point and OAM processor assign points here.
// - CPU-injected frames keep the point and action from their header.
// - Forward selector: 0 none, 1 copy, 2 redirect, 3 discard.
// - Classifier point field: 0 inner software, 1 outer software, 2 satellite, 3 reserved.
// - Frames injected at N are neither changed nor counted earlier; here one later extracted at M is counted at 0 to M.
// - Frames extracted at N are neither changed nor counted later.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "rewriter_pipe_consts.vh"

module egress_rewriter_pipeline_control #(
	parameter ADDR_W = 8,
	parameter QUEUE_W = 3
) (
	input wire core_clk,
	input wire arst_n,
	input wire ce,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire frameValid,
	input wire [3:0] inPipePoint,
	input wire [3:0] inPipeAction,
	input wire [1:0] inAnalyzerPoint,
	input wire inFromCpu,
	input wire inAlreadyLooped,
	input wire [47:0] inDestMac,
	input wire [47:0] inSourceMac,
	input wire [1:0] forwardSelector,
	input wire pipeActionBit,
	input wire [1:0] pipePointSelect,
	input wire [QUEUE_W-1:0] cpuQueueSelect,
	input wire macExchangeEnable,
	input wire forcedLoop,
	input wire mipValid,
	input wire mipOuter,
	input wire [1:0] mipForward,
	input wire [QUEUE_W-1:0] mipQueue,
	input wire oamValid,
	input wire [1:0] oamPointSelect,
	input wire [1:0] oamForward,
	input wire oamUpEndpoint,
	input wire [QUEUE_W-1:0] oamQueue,
	output reg outValid,
	output reg [3:0] outPipePoint,
	output reg [3:0] outPipeAction,
	output reg [1:0] outForward,
	output reg outCpuCopy,
	output reg outCpuRedirect,
	output reg [QUEUE_W-1:0] outCpuQueue,
	output reg outLooped,
	output reg [47:0] outDestMac,
	output reg [47:0] outSourceMac,
	output reg [`PT_COUNT-1:0] outCountMask
);
	reg [1:0] ctrl_reg;
	reg [31:0] frames_reg;
	reg [31:0] loops_reg;
	reg [ADDR_W-1:0] awAddr_reg;
	reg awHeld_reg;
	reg [31:0] wData_reg;
	reg [3:0] wStrb_reg;
	reg wHeld_reg;

	reg [3:0] pt;
	reg [3:0] act;
	reg [1:0] fwd;
	reg cpuCopy;
	reg cpuRedir;
	reg swap;
	reg looped;
	reg [QUEUE_W-1:0] queue;
	reg [3:0] clsPos;
	reg [1:0] clsFwd;
	reg clsLbk;
	reg clsSwap;
	reg clsForced;
	reg [3:0] oamPos;
	reg [3:0] mipPos;
	reg reqHit;
	reg [1:0] reqFwd;
	reg reqLbk;
	reg reqUp;
	reg reqSwap;
	reg reqQueueUse;
	reg [QUEUE_W-1:0] reqQueue;
	reg [47:0] newSmac;
	integer p;
	wire [`PT_COUNT-1:0] presentMask;

	function allowedAt;
		input [3:0] pos;
		input [3:0] point;
		input [3:0] action;
		reg injectLike;
		reg extractLike;
		begin
			injectLike = (action == `ACT_INJECT) || (action == `ACT_INJECT_MASQUERADE) ||
				(action == `ACT_INJECT_CENTRAL) || (action == `ACT_QUEUE_SYSTEM_LOOPBACK);
			extractLike = (action == `ACT_EXTRACT) || (action == `ACT_EXTRACT_UP_ENDPOINT) ||
				(action == `ACT_EXTRACT_LATE) || (action == `ACT_LOOPBACK_TO_ANALYZER);
			allowedAt = injectLike ? (pos >= point) : (extractLike ? (pos <= point) : 1'b1);
		end
	endfunction

	// Classifier request decode.
	always @* begin
		clsPos = `PT_NONE;
		clsFwd = `FWD_NONE;
		clsLbk = 1'b0;
		clsSwap = 1'b0;
		clsForced = 1'b0;
		if (forcedLoop && !(ctrl_reg[`CTRL_LOOP_ONCE_BIT] && inAlreadyLooped)) begin
			// A suppressed forced loop must not hide the CPU queue of the normal path.
			clsForced = 1'b1;
			clsPos = `PT_SATELLITE_TEST;
			clsFwd = `FWD_REDIRECT;
			clsLbk = 1'b1;
			clsSwap = 1'b1;
		end else begin
			case (pipePointSelect)
				`CLS_PT_INNER_SW: clsPos = `PT_INNER_SOFTWARE_ENDPOINT;
				`CLS_PT_OUTER_SW: clsPos = `PT_OUTER_SOFTWARE_ENDPOINT;
				`CLS_PT_SAT: clsPos = `PT_SATELLITE_TEST;
				default: clsPos = `PT_NONE;
			endcase
			clsFwd = (clsPos == `PT_NONE) ? `FWD_NONE : forwardSelector;
			clsLbk = (forwardSelector != `FWD_NONE) && pipeActionBit;
			clsSwap = macExchangeEnable && ((forwardSelector == `FWD_COPY) ||
				(forwardSelector == `FWD_REDIRECT && pipeActionBit));
		end
		case (oamPointSelect)
			`OAM_PT_INNER: oamPos = `PT_INNER_SERVICE_OAM;
			`OAM_PT_OUTER: oamPos = `PT_OUTER_SERVICE_OAM;
			`OAM_PT_PORT: oamPos = `PT_PORT_OAM;
			default: oamPos = `PT_NONE;
		endcase
		mipPos = mipOuter ? `PT_OUTER_INTERMEDIATE : `PT_INNER_INTERMEDIATE;
	end

	// Walk the stages in position order; the frame visits each one physically.
	always @* begin
		pt = inPipePoint;
		act = inPipeAction;
		fwd = `FWD_NONE;
		cpuCopy = 1'b0;
		cpuRedir = 1'b0;
		swap = 1'b0;
		looped = 1'b0;
		queue = {QUEUE_W{1'b0}};
		reqHit = 1'b0;
		reqFwd = `FWD_NONE;
		reqLbk = 1'b0;
		reqUp = 1'b0;
		reqSwap = 1'b0;
		reqQueueUse = 1'b0;
		reqQueue = {QUEUE_W{1'b0}};
		if (!inFromCpu) begin
			case (inPipeAction)
				`ACT_INJECT, `ACT_INJECT_MASQUERADE, `ACT_INJECT_CENTRAL: begin
					pt = `PT_NONE;
					act = `ACT_NONE;
				end
				`ACT_QUEUE_SYSTEM_LOOPBACK: begin
					case (inAnalyzerPoint)
						`ANA_PT_PORT_OAM: pt = `PT_PORT_OAM;
						`ANA_PT_OUTER_OAM: pt = `PT_OUTER_SERVICE_OAM;
						`ANA_PT_INNER_OAM: pt = `PT_INNER_SERVICE_OAM;
						default: pt = `PT_NONE;
					endcase
				end
				default: begin
					pt = inPipePoint;
				end
			endcase
		end
		for (p = 1; p < `PT_COUNT; p = p + 1) begin
			// Only these three sources may assign a point inside the rewriter.
			reqHit = 1'b0;
			reqFwd = `FWD_NONE;
			reqLbk = 1'b0;
			reqUp = 1'b0;
			reqSwap = 1'b0;
			reqQueueUse = 1'b0;
			reqQueue = {QUEUE_W{1'b0}};
			if (clsPos == p[3:0] && clsFwd != `FWD_NONE) begin
				reqHit = 1'b1;
				reqFwd = clsFwd;
				reqLbk = clsLbk;
				reqSwap = clsSwap;
				reqQueueUse = !clsForced && !clsLbk;
				reqQueue = cpuQueueSelect;
			end else if (mipValid && mipPos == p[3:0] && mipForward != `FWD_NONE) begin
				reqHit = 1'b1;
				reqFwd = mipForward;
				reqQueueUse = 1'b1;
				reqQueue = mipQueue;
			end else if (oamValid && oamPos == p[3:0] && oamForward != `FWD_NONE) begin
				reqHit = 1'b1;
				reqFwd = oamForward;
				reqUp = oamUpEndpoint;
				reqQueueUse = 1'b1;
				reqQueue = oamQueue;
			end
			if (ctrl_reg[`CTRL_ENABLE_BIT] && reqHit && allowedAt(p[3:0], pt, act)) begin
				if (reqQueueUse) begin
					queue = reqQueue;
				end
				swap = swap | reqSwap;
				case (reqFwd)
					`FWD_COPY: begin
						cpuCopy = cpuCopy | reqQueueUse;
						looped = looped | reqLbk;
						if (fwd == `FWD_NONE) begin
							fwd = `FWD_COPY;
						end
					end
					`FWD_REDIRECT: begin
						fwd = `FWD_REDIRECT;
						pt = p[3:0];
						if (reqLbk) begin
							act = `ACT_LOOPBACK_TO_ANALYZER;
							looped = 1'b1;
						end else begin
							act = reqUp ? `ACT_EXTRACT_UP_ENDPOINT : `ACT_EXTRACT;
							cpuRedir = 1'b1;
						end
					end
					`FWD_DISCARD: begin
						fwd = `FWD_DISCARD;
						pt = p[3:0];
						act = reqUp ? `ACT_EXTRACT_UP_ENDPOINT : `ACT_EXTRACT;
					end
					default: begin
						fwd = fwd;
					end
				endcase
			end
		end
		newSmac = inDestMac;
		newSmac[`MAC_LOCAL_BIT] = 1'b0;
	end

	stage_presence_mask #(
		.NPOS(`PT_COUNT)
	) uMask (
		.point(pt),
		.action(act),
		.present(presentMask)
	);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			outValid <= 1'b0;
			outPipePoint <= `PT_NONE;
			outPipeAction <= `ACT_NONE;
			outForward <= `FWD_NONE;
			outCpuCopy <= 1'b0;
			outCpuRedirect <= 1'b0;
			outCpuQueue <= {QUEUE_W{1'b0}};
			outLooped <= 1'b0;
			outDestMac <= 48'h0;
			outSourceMac <= 48'h0;
			outCountMask <= {`PT_COUNT{1'b0}};
			frames_reg <= 32'h0;
			loops_reg <= 32'h0;
		end else if (ce) begin
			outValid <= frameValid;
			if (frameValid) begin
				outPipePoint <= pt;
				outPipeAction <= act;
				outForward <= fwd;
				outCpuCopy <= cpuCopy;
				outCpuRedirect <= cpuRedir;
				outCpuQueue <= queue;
				outLooped <= looped;
				outDestMac <= swap ? inSourceMac : inDestMac;
				outSourceMac <= swap ? newSmac : inSourceMac;
				outCountMask <= presentMask;
				frames_reg <= frames_reg + 32'h1;
				if (looped) begin
					loops_reg <= loops_reg + 32'h1;
				end
			end
		end
	end

	// AXI4-Lite slave; address and data are taken independently and joined for the response.
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= `CTRL_RESET;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h0;
			awAddr_reg <= {ADDR_W{1'b0}};
			awHeld_reg <= 1'b0;
			wData_reg <= 32'h0;
			wStrb_reg <= 4'h0;
			wHeld_reg <= 1'b0;
		end else if (ce) begin
			if (s_axi_awready && s_axi_awvalid) begin
				awAddr_reg <= s_axi_awaddr;
				awHeld_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
				wHeld_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awAddr_reg[ADDR_W-1:2] == `REG_CTRL_OFS >> 2) begin
					s_axi_bresp <= `RESP_OKAY;
					if (wStrb_reg[0]) begin
						ctrl_reg <= wData_reg[1:0];
					end
				end else if (awAddr_reg[ADDR_W-1:2] == `REG_STATUS_OFS >> 2 ||
					awAddr_reg[ADDR_W-1:2] == `REG_FRAMES_OFS >> 2 ||
					awAddr_reg[ADDR_W-1:2] == `REG_LOOPS_OFS >> 2) begin
					// Read-only registers ignore writes silently.
					s_axi_bresp <= `RESP_OKAY;
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (s_axi_araddr[ADDR_W-1:2])
					`REG_CTRL_OFS >> 2: s_axi_rdata <= {30'h0, ctrl_reg};
					`REG_STATUS_OFS >> 2: s_axi_rdata <= {22'h0, outForward, outPipeAction, outPipePoint};
					`REG_FRAMES_OFS >> 2: s_axi_rdata <= frames_reg;
					`REG_LOOPS_OFS >> 2: s_axi_rdata <= loops_reg;
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

/* sim/egress_rewriter_pipeline_control_properties.sv */
`timescale 1ns/1ps
module egress_rewriter_pipeline_control_properties (
	input logic core_clk,
	input logic arst_n,
	input logic ce,
	input logic frameValid,
	input logic [3:0] inPipePoint,
	input logic [3:0] inPipeAction,
	input logic [1:0] inAnalyzerPoint,
	input logic inFromCpu,
	input logic inAlreadyLooped,
	input logic [47:0] inDestMac,
	input logic [47:0] inSourceMac,
	input logic [1:0] forwardSelector,
	input logic pipeActionBit,
	input logic [1:0] pipePointSelect,
	input logic forcedLoop,
	input logic mipValid,
	input logic oamValid,
	input logic outValid,
	input logic [3:0] outPipePoint,
	input logic [3:0] outPipeAction,
	input logic [1:0] outForward,
	input logic [47:0] outDestMac,
	input logic [47:0] outSourceMac
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence take;
		frameValid && ce;
	endsequence
	// A frame that only the classifier acts on, so no earlier stage can block it.
	sequence quiet;
		take ##0 (!mipValid && !oamValid && inPipeAction == 4'h0);
	endsequence
	sequence idle;
		take ##0 (!mipValid && !oamValid && forwardSelector == 2'h0 && !forcedLoop);
	endsequence
	AST_PULSE: assert property (take |=> outValid) else $error("no output pulse");
	AST_IDLE: assert property (!frameValid && ce |=> !outValid) else $error("stray output pulse");
	AST_FORCE: assert property (quiet ##0 (forcedLoop && !inAlreadyLooped)
		|=> outPipePoint == 4'h7 && outPipeAction == 4'h7 && outForward == 2'h2) else $error("forced loop wrong");
	AST_SWAP: assert property (quiet ##0 (forcedLoop && !inAlreadyLooped) |=> outDestMac == $past(inSourceMac)
		&& outSourceMac == ($past(inDestMac) & ~(48'h1 << 40))) else $error("mac exchange wrong");
	AST_KEEP: assert property (quiet ##0 (!forcedLoop && forwardSelector == 2'h2 && !pipeActionBit)
		|=> outDestMac == $past(inDestMac) && outSourceMac == $past(inSourceMac)) else $error("macs changed");
	AST_DISC: assert property (quiet ##0 (!forcedLoop && forwardSelector == 2'h3 && pipePointSelect == 2'h2)
		|=> outForward == 2'h3 && outPipePoint == 4'h7) else $error("discard wrong");
	AST_INJ: assert property (idle ##0 (!inFromCpu && inPipeAction inside {4'h1, 4'h2, 4'h3})
		|=> outPipePoint == 4'h0 && outPipeAction == 4'h0) else $error("injection not cleared");
	AST_CPU: assert property (idle ##0 inFromCpu
		|=> outPipePoint == $past(inPipePoint) && outPipeAction == $past(inPipeAction)) else $error("cpu header lost");
	AST_XLAT: assert property (take ##0 (!mipValid && !oamValid && !inFromCpu && inPipeAction == 4'h8 &&
		inAnalyzerPoint == 2'h1)
		|=> outPipePoint == 4'h8) else $error("point not translated");
endmodule
bind egress_rewriter_pipeline_control egress_rewriter_pipeline_control_properties u_props (.*);

/* sim/oam_agent.sv */
`timescale 1ns/1ps
module oam_agent (
	input logic frameValid,
	input logic [8:0] oamCmd,
	output logic oamValid,
	output logic [1:0] oamPointSelect,
	output logic [1:0] oamForward,
	output logic oamUpEndpoint,
	output logic [2:0] oamQueue
);
	// Between frames the payload is inverted, so a late sample sees wrong values.
	assign oamValid = frameValid & oamCmd[8];
	assign {oamPointSelect, oamForward, oamUpEndpoint, oamQueue} = frameValid ? oamCmd[7:0] : ~oamCmd[7:0];
endmodule

/* sim/egress_rewriter_pipeline_control_test.sv */
`timescale 1ns/1ps
`include "rewriter_pipe_consts.vh"
module egress_rewriter_pipeline_control_test;
	logic core_clk, arst_n;
	logic ce = 1'h1;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic frameValid, inFromCpu, inAlreadyLooped, pipeActionBit, macExchangeEnable, forcedLoop, mipValid, mipOuter;
	logic [3:0] inPipePoint, inPipeAction, outPipePoint, outPipeAction;
	logic [1:0] inAnalyzerPoint, forwardSelector, pipePointSelect, mipForward, oamPointSelect, oamForward, outForward;
	logic [2:0] cpuQueueSelect, mipQueue, oamQueue, outCpuQueue;
	logic [8:0] oamCmd;
	logic oamValid, oamUpEndpoint, outValid, outCpuCopy, outCpuRedirect, outLooped;
	logic [47:0] inDestMac = 48'hffeeddccbbaa, inSourceMac = 48'h112233445566, outDestMac, outSourceMac, swapped;
	logic [9:0] outCountMask;
	int n_fail = 0, compares = 0, frames = 0, i, j, ep;
	egress_rewriter_pipeline_control u_egress_rewriter_pipeline_control (.*);
	oam_agent u_oam_agent (.*);
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	task chk(input logic [47:0] g, input logic [47:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task conclude;
		if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task clr;
		{inPipePoint, inPipeAction, inAnalyzerPoint, inFromCpu, inAlreadyLooped, oamCmd} <= '0;
		{forwardSelector, pipeActionBit, pipePointSelect, cpuQueueSelect, macExchangeEnable, forcedLoop} <= '0;
		{mipValid, mipOuter, mipForward, mipQueue} <= '0;
	endtask
	task fr;
		frameValid <= 1'h1;
		@(posedge core_clk);
		frameValid <= 1'h0;
		frames++;
		@(posedge core_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, r);
		@(posedge core_clk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, r);
		@(posedge core_clk);
	endtask
	initial begin
		#100000;
		n_fail++;
		conclude;
	end
	initial begin
		clr;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, frameValid} <= '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		swapped = inDestMac & ~(48'h1 << `MAC_LOCAL_BIT);
		arst_n <= 1'h0;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'h1;
		@(posedge core_clk);
		wr(8'h10, 32'h2, `RESP_SLVERR);
		rd(8'h20, 32'h0, `RESP_SLVERR);
		rd(`REG_CTRL_OFS, 32'h1, `RESP_OKAY);
		pipePointSelect <= 2'h3;
		fr;
		chk({outPipePoint, outPipeAction}, 8'h00);
		chk(outCountMask, 10'h3ff);
		for (i = 0; i < 4; i++) begin
			clr;
			forwardSelector <= i;
			cpuQueueSelect <= 3'h4;
			macExchangeEnable <= 1'h1;
			fr;
			chk(outForward, i);
			chk(outPipePoint, i > 1 ? 2 : 0);
			chk(outPipeAction, i > 1 ? 4 : 0);
			chk(outCpuCopy, i == 1);
			if (i == 1 || i == 2) chk(outCpuQueue, 3'h4);
			chk(outSourceMac, i == 1 ? swapped : inSourceMac);
		end
		for (i = 0; i < 3; i++) begin
			clr;
			forwardSelector <= 2'h3;
			pipePointSelect <= i;
			fr;
			chk(outPipePoint, i == 0 ? 2 : i == 1 ? 5 : 7);
		end
		clr;
		{forwardSelector, pipeActionBit, pipePointSelect, macExchangeEnable} <= 6'h2b;
		fr;
		chk(outPipeAction, `ACT_LOOPBACK_TO_ANALYZER);
		chk({outPipePoint, outLooped}, 5'hb);
		chk(outDestMac, inSourceMac);
		clr;
		forcedLoop <= 1'h1;
		cpuQueueSelect <= 3'h6;
		fr;
		chk(outCpuQueue, 3'h0);
		chk(outSourceMac, swapped);
		for (j = 0; j < 2; j++) begin
			for (i = 1; i < 4; i++) begin
				clr;
				inFromCpu <= j;
				inPipeAction <= i;
				inPipePoint <= 4'h9;
				fr;
				chk(outPipePoint, j ? 9 : 0);
				chk(outPipeAction, j ? i : 0);
			end
		end
		for (i = 1; i < 4; i++) begin
			clr;
			inPipeAction <= `ACT_QUEUE_SYSTEM_LOOPBACK;
			inAnalyzerPoint <= i;
			forwardSelector <= 2'h2;
			fr;
			ep = i == 1 ? 8 : i == 2 ? 4 : 3;
			chk(outPipePoint, ep);
			chk(outForward, 2'h0);
			chk(outCountMask, 10'(10'h3ff << ep));
		end
		clr;
		{mipValid, mipForward, mipQueue} <= 6'h35;
		{forwardSelector, pipeActionBit, pipePointSelect} <= 5'h16;
		fr;
		chk({outPipePoint, outPipeAction}, 8'h14);
		chk({outCpuQueue, outLooped}, 4'ha);
		chk(outCountMask, 10'h003);
		wr(`REG_STATUS_OFS, 32'hffffffff, `RESP_OKAY);
		rd(`REG_STATUS_OFS, 32'h241, `RESP_OKAY);
		clr;
		oamCmd <= {1'h1, `OAM_PT_INNER, `FWD_REDIRECT, 1'h1, 3'h2};
		pipePointSelect <= 2'h3;
		fr;
		chk({outPipePoint, outPipeAction}, 8'h35);
		chk({outCpuRedirect, outCpuQueue}, 4'ha);
		wr(`REG_CTRL_OFS, 32'h3, `RESP_OKAY);
		rd(`REG_CTRL_OFS, 32'h3, `RESP_OKAY);
		clr;
		{forcedLoop, inAlreadyLooped, pipePointSelect} <= 4'hf;
		fr;
		chk({outForward, outLooped}, 3'h0);
		rd(`REG_FRAMES_OFS, frames, `RESP_OKAY);
		wr(`REG_CTRL_OFS, 32'h0, `RESP_OKAY);
		clr;
		forwardSelector <= `FWD_DISCARD;
		fr;
		chk(outForward, 2'h0);
		chk(outPipePoint, 4'h0);
		wr(`REG_CTRL_OFS, 32'h1, `RESP_OKAY);
		ce <= 1'h0;
		fr;
		ce <= 1'h1;
		chk(outForward, 2'h0);
		rd(`REG_FRAMES_OFS, frames - 1, `RESP_OKAY);
		conclude;
	end
endmodule
